//--- verilog/adc_result_alert_registers.sv
// Register bank of a two-wire ADC: pointer, result, alert status and the
// other data registers, byte access from the bus controller logic.
// Assumes the bus front end delivers byte strobes on this clock and that
// the converter returns results on this clock as well.
`timescale 1ns/10ps

// How it works
// - first written byte loads the pointer
// - three low pointer bits select register
// - pointer resets to zero, selecting result
// - result at zero, read-only, resets zero
// - bit 15 is gated alert summary
// - bits 11:0 hold latest conversion
// - status at one, resets zero, read-write
// - status bits 7:2 read zero
// - over flag sets above high limit
// - over flag self-clears below high minus hysteresis
// - writing one clears over flag
// - under flag sets below low limit
// - under flag self-clears above low plus hysteresis
// - writing one clears under flag
// - result read or auto timer starts conversion
// - config bit 4 selects alert hold
// - config bit 3 enables summary bit
module adc_result_alert_registers
	import adc_regs_pkg::*;
#(
	parameter int AUTO_UNIT = AUTO_UNIT_CYCLES // Cycles per auto-conversion unit
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Transaction framing from the bus front end
	input wire logic txn_start,
	input wire logic txn_is_write,
	// Write byte strobe
	input wire logic wr_valid,
	input wire logic [7:0] wr_byte,
	// Read byte request and answer
	input wire logic rd_req,
	output logic rd_ack,
	output logic [7:0] rd_byte,
	// Converter side
	output logic conv_start,
	input wire conv_in_s conv,
	// Alert flag levels
	output logic [1:0] alert_flags_out
);

	logic rst_meta_q; // Reset release, first stage
	logic rst_sync_q; // Reset release, usable copy
	bank_state_s cur_q; // Registered state
	bank_state_s nxt_d; // Next state
	logic [1:0] flags; // Over and under flags
	logic [1:0] clr; // Write-one-to-clear pulses
	alert_cfg_s acfg; // Limits handed to the flag unit
	logic [15:0] word; // Word selected by the pointer
	logic [31:0] auto_limit; // Current auto-conversion interval
	logic [2:0] cycle_code; // Automatic conversion code
	logic [2:0] sel; // Decoded register select

	// Register read view for a select code
	function automatic logic [15:0] read_word(input logic [2:0] s, input bank_state_s st,
		input logic [1:0] fl);
		logic [15:0] w;
		w = 16'h0000;
		case (s)
			SEL_RESULT: w = {st.config_r[CFG_FLAG_EN_BIT] & (|fl), 3'h0,
				st.result[11:0]};
			SEL_STATUS: w = {8'h00, 6'h00, fl};
			SEL_CONFIG: w = {8'h00, st.config_r & CONFIG_WMASK};
			SEL_LOW: w = {4'h0, st.low};
			SEL_HIGH: w = {4'h0, st.high};
			SEL_HYST: w = {4'h0, st.hyst};
			SEL_LOWEST: w = {4'h0, st.lowest};
			default: w = {4'h0, st.highest};
		endcase
		return w;
	endfunction

	// Narrow registers answer in one byte
	function automatic logic is_byte_reg(input logic [2:0] s);
		return (s == SEL_STATUS) || (s == SEL_CONFIG);
	endfunction

	// Reset release through two flops; asserts at once, releases on the clock
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign sel = cur_q.pointer[2:0];
	assign word = read_word(sel, cur_q, flags);
	assign cycle_code = cur_q.config_r[CFG_CYCLE_LSB +: 3];
	// Interval grows as 32, 64 ... 2048 units for codes 1 to 7
	assign auto_limit = 32'(AUTO_UNIT) << (AUTO_SHIFT_BASE + 32'(cycle_code));
	assign acfg = '{low: cur_q.low, high: cur_q.high, hyst: cur_q.hyst,
		hold: cur_q.config_r[CFG_HOLD_BIT]};

	// Clear pulses come from a committed status write; framing has priority
	assign clr = (!txn_start && wr_valid && txn_is_write && cur_q.phase == PH_MSB &&
		sel == SEL_STATUS) ? (wr_byte[1:0] & STATUS_WMASK[1:0]) : 2'b00;

	// Over and under flags
	alert_flags u_flags (
		.clk(sys_clk),
		.rst_n(rst_sync_q),
		.conv(conv),
		.acfg(acfg),
		.clr(clr),
		.flags(flags)
	);

	// Next state of the bank
	always_comb
	begin
		nxt_d = cur_q;
		nxt_d.rd_ack = 1'b0;
		nxt_d.conv_start = 1'b0;
		// Transaction start: writes begin with the pointer byte
		if (txn_start)
		begin
			nxt_d.phase = txn_is_write ? PH_PTR : PH_MSB;
			// Reading the result starts a new conversion
			if (!txn_is_write && sel == SEL_RESULT && !cur_q.busy)
			begin
				nxt_d.conv_start = 1'b1;
				nxt_d.busy = 1'b1;
			end
		end
		else if (wr_valid && txn_is_write)
		begin
			case (cur_q.phase)
				PH_PTR:
				begin
					// Whole byte is stored; only low three bits decode
					nxt_d.pointer = wr_byte;
					nxt_d.phase = PH_MSB;
				end
				PH_MSB:
				begin
					// Byte-wide registers commit here, others keep the high byte
					if (sel == SEL_CONFIG)
						nxt_d.config_r = wr_byte & CONFIG_WMASK;
					nxt_d.msb_hold = wr_byte;
					nxt_d.phase = is_byte_reg(sel) ? PH_MSB : PH_LSB;
				end
				PH_LSB:
				begin
					// Full word known: commit; result register ignores writes
					case (sel)
						SEL_LOW: nxt_d.low = {cur_q.msb_hold[3:0], wr_byte};
						SEL_HIGH: nxt_d.high = {cur_q.msb_hold[3:0], wr_byte};
						SEL_HYST: nxt_d.hyst = {cur_q.msb_hold[3:0], wr_byte};
						SEL_LOWEST: nxt_d.lowest = {cur_q.msb_hold[3:0], wr_byte};
						SEL_HIGHEST: nxt_d.highest = {cur_q.msb_hold[3:0], wr_byte};
						default: nxt_d.result = cur_q.result;
					endcase
					nxt_d.phase = PH_MSB;
				end
				default: nxt_d.phase = PH_PTR;
			endcase
		end
		else if (rd_req)
		begin
			// High byte first for word registers, then low byte, repeating
			nxt_d.rd_ack = 1'b1;
			if (is_byte_reg(sel) || cur_q.phase == PH_LSB)
			begin
				nxt_d.rd_data = word[7:0];
				nxt_d.phase = PH_MSB;
			end
			else
			begin
				nxt_d.rd_data = word[15:8];
				nxt_d.phase = PH_LSB;
			end
		end
		// Automatic conversion timer; code zero disables it
		if (cycle_code == 3'h0)
			nxt_d.auto_cnt = '0;
		else if (cur_q.auto_cnt >= auto_limit - 32'h1)
		begin
			nxt_d.auto_cnt = '0;
			if (!cur_q.busy)
			begin
				nxt_d.conv_start = 1'b1;
				nxt_d.busy = 1'b1;
			end
		end
		else
			nxt_d.auto_cnt = cur_q.auto_cnt + 32'h1;
		// Store the finished conversion and track extremes
		if (conv.done)
		begin
			nxt_d.result = {4'h0, conv.value};
			nxt_d.busy = 1'b0;
			if (conv.value < cur_q.lowest)
				nxt_d.lowest = conv.value;
			if (conv.value > cur_q.highest)
				nxt_d.highest = conv.value;
		end
	end

	// State register; reset clears pointer and result
	always_ff @(posedge sys_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			cur_q <= '0;
			cur_q.pointer <= POINTER_RESET;
			cur_q.result <= RESULT_RESET;
			cur_q.config_r <= CONFIG_RESET;
			cur_q.low <= LOW_RESET;
			cur_q.high <= HIGH_RESET;
			cur_q.hyst <= HYST_RESET;
			cur_q.lowest <= LOWEST_RESET;
			cur_q.highest <= HIGHEST_RESET;
			cur_q.phase <= PH_PTR;
		end
		else
			cur_q <= nxt_d;
	end

	assign rd_ack = cur_q.rd_ack;
	assign rd_byte = cur_q.rd_data;
	assign conv_start = cur_q.conv_start;
	assign alert_flags_out = flags;

endmodule // adc_result_alert_registers

//--- verilog/adc_regs_pkg.sv
// Constants, types and register layout of the result/alert register bank.
// Assumes a single device clock; shared by the bank and its alert flag unit.
package adc_regs_pkg;

	// Register select codes (three low pointer bits)
	localparam logic [2:0] SEL_RESULT = 3'h0;
	localparam logic [2:0] SEL_STATUS = 3'h1;
	localparam logic [2:0] SEL_CONFIG = 3'h2;
	localparam logic [2:0] SEL_LOW = 3'h3;
	localparam logic [2:0] SEL_HIGH = 3'h4;
	localparam logic [2:0] SEL_HYST = 3'h5;
	localparam logic [2:0] SEL_LOWEST = 3'h6;
	localparam logic [2:0] SEL_HIGHEST = 3'h7;

	// Values after reset
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [11:0] LOW_RESET = 12'h000;
	localparam logic [11:0] HIGH_RESET = 12'hFFF;
	localparam logic [11:0] HYST_RESET = 12'h000;
	localparam logic [11:0] LOWEST_RESET = 12'hFFF;
	localparam logic [11:0] HIGHEST_RESET = 12'h000;

	// Field positions
	localparam int RES_ALERT_BIT = 15;
	localparam int STAT_OVER_BIT = 1;
	localparam int STAT_UNDER_BIT = 0;
	localparam int CFG_HOLD_BIT = 4;
	localparam int CFG_FLAG_EN_BIT = 3;
	localparam int CFG_CYCLE_LSB = 5;
	localparam logic [7:0] CONFIG_WMASK = 8'hFD;
	localparam logic [7:0] STATUS_WMASK = 8'h03;

	// Automatic conversion interval base multiple (32 x base at code 1)
	localparam int AUTO_SHIFT_BASE = 4;
	// Default unit period of automatic conversion, cycles
	localparam int AUTO_UNIT_CYCLES = 256;

	// Byte phase within a transaction
	typedef enum logic [1:0] {PH_PTR, PH_MSB, PH_LSB} phase_e;

	// Conversion result handed over by the converter
	typedef struct packed {
		logic done;
		logic [11:0] value;
	} conv_in_s;

	// Limits and mode seen by the alert flag unit
	typedef struct packed {
		logic [11:0] low;
		logic [11:0] high;
		logic [11:0] hyst;
		logic hold;
	} alert_cfg_s;

	// Whole state of the register bank
	typedef struct packed {
		logic [7:0] pointer;
		logic [15:0] result;
		logic [7:0] config_r;
		logic [11:0] low;
		logic [11:0] high;
		logic [11:0] hyst;
		logic [11:0] lowest;
		logic [11:0] highest;
		phase_e phase;
		logic [7:0] msb_hold;
		logic [7:0] rd_data;
		logic rd_ack;
		logic conv_start;
		logic busy;
		logic [31:0] auto_cnt;
	} bank_state_s;

endpackage

//--- verilog/alert_flags.sv
// Over-range and under-range alert flags with hysteresis self-clear.
// Assumes conversion results and clear pulses arrive on the same clock.
`timescale 1ns/10ps
module alert_flags
	import adc_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Conversion and limits
	input wire conv_in_s conv,
	input wire alert_cfg_s acfg,
	// Write-one-to-clear strobes
	input wire logic [1:0] clr,
	// Flag outputs, bit 1 over, bit 0 under
	output logic [1:0] flags
);

	// All state of this unit
	typedef struct packed {
		logic over;
		logic under;
	} flag_state_s;

	flag_state_s cur_q; // Registered flags
	flag_state_s nxt_d; // Next flags
	logic [12:0] up_sum; // Value plus hysteresis, no wrap
	logic [12:0] low_sum; // Low limit plus hysteresis, no wrap

	// Sums kept one bit wider so adding hysteresis to a 12-bit value never wraps
	assign up_sum = {1'b0, conv.value} + {1'b0, acfg.hyst};
	assign low_sum = {1'b0, acfg.low} + {1'b0, acfg.hyst};

	// Next flag values; a set in the same cycle beats any clear
	always_comb
	begin
		nxt_d = cur_q;
		// Controller clear first, so a fresh set below overrides it
		if (clr[STAT_OVER_BIT])
			nxt_d.over = 1'b0;
		if (clr[STAT_UNDER_BIT])
			nxt_d.under = 1'b0;
		if (conv.done)
		begin
			// Over range: set above high, self-clear below high minus hysteresis
			if (conv.value > acfg.high)
				nxt_d.over = 1'b1;
			else if (!acfg.hold && (up_sum < {1'b0, acfg.high}))
				nxt_d.over = 1'b0;
			// Under range: set below low, self-clear above low plus hysteresis
			if (conv.value < acfg.low)
				nxt_d.under = 1'b1;
			else if (!acfg.hold && ({1'b0, conv.value} > low_sum))
				nxt_d.under = 1'b0;
		end
	end

	// Flag registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cur_q <= '0;
		else
			cur_q <= nxt_d;
	end

	assign flags = {cur_q.over, cur_q.under};

endmodule // alert_flags

//--- test/adc_regs_props.sv
// Port checker of the result and alert register bank.
// Assumes one clock domain, sys_clk with reset_n.
`timescale 1ns/10ps
module adc_regs_props
	import adc_regs_pkg::*;
#(
	parameter int AUTO_UNIT = AUTO_UNIT_CYCLES // Cycles per auto unit
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Bus side
	input wire logic txn_start,
	input wire logic txn_is_write,
	input wire logic wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic rd_req,
	input wire logic rd_ack,
	input wire logic [7:0] rd_byte,
	// Converter and flags
	input wire logic conv_start,
	input wire conv_in_s conv,
	input wire logic [1:0] alert_flags_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Plain read request, not shadowed by framing or a write
	chk_ack_after_req: assert property (
		rd_req && !txn_start && !(wr_valid && txn_is_write) |=> rd_ack)
		else $error("read request not answered");
	chk_ack_has_cause: assert property (rd_ack |-> $past(rd_req))
		else $error("read answer without request");
	// Read byte must not drift between answers
	chk_byte_held: assert property (!rd_ack |-> $stable(rd_byte))
		else $error("read byte changed without answer");
	// Conversion start is a one-cycle pulse
	chk_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	chk_over_rise: assert property ($rose(alert_flags_out[1]) |-> $past(conv.done))
		else $error("over flag set without conversion");
	chk_under_rise: assert property ($rose(alert_flags_out[0]) |-> $past(conv.done))
		else $error("under flag set without conversion");
	chk_over_fall: assert property ($fell(alert_flags_out[1]) |->
		$past(conv.done) || $past(wr_valid && txn_is_write))
		else $error("over flag cleared without cause");
	chk_under_fall: assert property ($fell(alert_flags_out[0]) |->
		$past(conv.done) || $past(wr_valid && txn_is_write))
		else $error("under flag cleared without cause");
	// Main scenarios
	cov_read: cover property (rd_req ##1 rd_ack);
	cov_over: cover property ($rose(alert_flags_out[1]));
	cov_under_clr: cover property ($fell(alert_flags_out[0]));
endmodule // adc_regs_props

bind adc_result_alert_registers adc_regs_props #(.AUTO_UNIT(AUTO_UNIT)) chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .txn_start(txn_start),
	.txn_is_write(txn_is_write), .wr_valid(wr_valid), .wr_byte(wr_byte),
	.rd_req(rd_req), .rd_ack(rd_ack), .rd_byte(rd_byte), .conv_start(conv_start),
	.conv(conv), .alert_flags_out(alert_flags_out));

//--- test/conv_model.sv
// Behavioural converter answering conversion starts after a short delay.
// Assumes starts arrive on the bank clock; level is set by the bench.
`timescale 1ns/10ps
module conv_model
	import adc_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request and analog level
	input wire logic start,
	input wire logic [11:0] level,
	// Result to the bank
	output conv_in_s conv
);
	logic [1:0] cnt_q; // Cycles left in conversion
	logic busy_q; // Conversion running
	// Value toggles outside done so a stale sample never looks valid
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			conv <= '0;
			cnt_q <= 2'h0;
			busy_q <= 1'b0;
		end
		else
		begin
			conv.done <= 1'b0;
			conv.value <= ~conv.value;
			if (start)
			begin
				busy_q <= 1'b1;
				cnt_q <= 2'h2;
			end
			else if (busy_q && cnt_q == 2'h0)
			begin
				busy_q <= 1'b0;
				conv.done <= 1'b1;
				conv.value <= level;
			end
			else if (busy_q)
				cnt_q <= cnt_q - 2'h1;
		end
endmodule // conv_model

//--- test/adc_result_alert_registers_tb.sv
// Self-checking bench of the result and alert register bank.
// Assumes the converter model in place of the analog side.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module adc_result_alert_registers_tb;
	import adc_regs_pkg::*;
	logic sys_clk, reset_n, txn_start, txn_is_write, wr_valid, rd_req, rd_ack, conv_start;
	logic [7:0] wr_byte, rd_byte;
	logic [1:0] alert_flags_out;
	logic [11:0] cv; // Level the converter will report
	logic [15:0] v; // Last value read
	conv_in_s conv;
	int fail_count, num_checks;
	adc_result_alert_registers #(.AUTO_UNIT(1)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.txn_start(txn_start), .txn_is_write(txn_is_write), .wr_valid(wr_valid),
		.wr_byte(wr_byte), .rd_req(rd_req), .rd_ack(rd_ack), .rd_byte(rd_byte),
		.conv_start(conv_start), .conv(conv), .alert_flags_out(alert_flags_out));
	conv_model conv_far (.clk(sys_clk), .rst_n(reset_n), .start(conv_start),
		.level(cv), .conv(conv));
	// Free-running clock, 4 ns
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Verdict and end of run
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Framing pulse of one cycle
	task txn(input logic w);
		@(negedge sys_clk) txn_start = 1'b1;
		txn_is_write = w;
		@(negedge sys_clk) txn_start = 1'b0;
	endtask
	// Written byte; valid stays up for back-to-back bytes
	task wb(input logic [7:0] d);
		wr_valid = 1'b1;
		wr_byte = d;
		@(negedge sys_clk);
	endtask
	// One read byte, bounded wait for the answer
	task rb;
		int i;
		rd_req = 1'b1;
		@(negedge sys_clk) rd_req = 1'b0;
		for (i = 0; i < 4 && rd_ack !== 1'b1; i++) @(negedge sys_clk);
		if (rd_ack === 1'b1)
		begin
			v = {v[7:0], rd_byte};
			@(negedge sys_clk);
		end
		else
		begin
			fail_count++;
			conclude();
		end
	endtask
	// Pointer byte first, then data bytes MSB first
	task wr(input logic [7:0] p, input logic [15:0] d, input int n);
		txn(1'b1);
		wb(p);
		if (n == 2) wb(d[15:8]);
		wb(d[7:0]);
		wr_valid = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	// Set pointer, then read n bytes
	task rd(input logic [7:0] p, input int n);
		txn(1'b1);
		wb(p);
		wr_valid = 1'b0;
		txn(1'b0);
		v = 16'h0000;
		repeat (n) rb();
	endtask
	// Result read starts a conversion of level x
	task convert(input logic [11:0] x);
		cv = x;
		rd(8'h00, 0);
		repeat (6) @(negedge sys_clk);
	endtask
	// Main sequence
	initial
	begin
		{txn_start, txn_is_write, wr_valid, rd_req, wr_byte, cv, v} = '0;
		fail_count = 0;
		num_checks = 0;
		reset_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		// Reset pointer selects result without a pointer write
		txn(1'b0);
		repeat (2) rb();
		`CHK("result", RESULT_RESET, v)
		rd(8'h01, 1);
		`CHK("status", STATUS_RESET, v[7:0])
		// Limits, reserved nibble masked
		wr(8'h04, 16'hF800, 2);
		wr(8'h03, 16'h0100, 2);
		wr(8'h05, 16'h0010, 2);
		rd(8'h04, 2);
		`CHK("high", 16'h0800, v)
		rd(8'h05, 2);
		`CHK("hyst", 16'h0010, v)
		wr(8'h02, 16'h0008, 1);
		rd(8'h02, 1);
		`CHK("config", 8'h08, v[7:0])
		// Over range, summary enabled, self-clear at boundary
		convert(12'h900);
		`CHK("flags", 2'b10, alert_flags_out)
		rd(8'h01, 1);
		`CHK("status", 8'h02, v[7:0])
		rd(8'h00, 2);
		`CHK("result", 16'h8900, v)
		convert(12'h7F5);
		`CHK("flags", 2'b10, alert_flags_out)
		convert(12'h7EF);
		`CHK("flags", 2'b00, alert_flags_out)
		// Under range and its self-clear boundary
		convert(12'h0FF);
		`CHK("flags", 2'b01, alert_flags_out)
		convert(12'h110);
		`CHK("flags", 2'b01, alert_flags_out)
		convert(12'h111);
		`CHK("flags", 2'b00, alert_flags_out)
		// Hold mode: only a one written clears
		wr(8'h02, 16'h0018, 1);
		convert(12'h900);
		convert(12'h400);
		`CHK("flags", 2'b10, alert_flags_out)
		wr(8'h01, 16'h0002, 1);
		`CHK("flags", 2'b00, alert_flags_out)
		convert(12'h050);
		convert(12'h400);
		`CHK("flags", 2'b01, alert_flags_out)
		wr(8'h01, 16'h0001, 1);
		`CHK("flags", 2'b00, alert_flags_out)
		// Summary disabled, result ignores writes
		wr(8'h02, 16'h0010, 1);
		convert(12'h900);
		wr(8'h00, 16'hABCD, 2);
		rd(8'h00, 2);
		`CHK("result", 16'h0900, v)
		// Automatic mode, code 1: interval 32 units, no hold, summary off
		cv = 12'h123;
		wr(8'h02, 16'h0020, 1);
		repeat (80) @(negedge sys_clk);
		rd(8'h00, 2);
		`CHK("auto result", 16'h0123, v)
		`CHK("flags", 2'b00, alert_flags_out)
		rd(8'h01, 1);
		`CHK("status", 8'h00, v[7:0])
		// Reset in mid-run puts the pointer back on the result
		reset_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		txn(1'b0);
		repeat (2) rb();
		`CHK("result", RESULT_RESET, v)
		`CHK("flags", 2'b00, alert_flags_out)
		conclude();
	end
endmodule // adc_result_alert_registers_tb
